// ===== design/dsp_consts.vh
// constants shared by the drive supervision parameter bank
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// ***************************************************************
// parameter addresses
// ***************************************************************
`define DSP_ADDR_BRAKE_SEL       16'h0512
`define DSP_ADDR_PHASE_RESP      16'h0514
`define DSP_ADDR_FOLLOW_RESP     16'h0516
`define DSP_ADDR_PHASE_MON_EN    16'h051e
`define DSP_ADDR_GROUND_MON_EN   16'h0520
`define DSP_ADDR_EXT_ON_MAX      16'h0522
`define DSP_ADDR_SOFT_LIM_EN     16'h0606
`define DSP_ADDR_INT_BRAKE_RES   16'h1010
`define DSP_ADDR_INT_BRAKE_PWR   16'h1012
`define DSP_ADDR_FOLLOW_LIMIT    16'h121c
`define DSP_ADDR_SPEED_SRC       16'h1b22
`define DSP_ADDR_SPEED_SETPOINT  16'h2108

// ***************************************************************
// reset values and legal ranges
// ***************************************************************
`define DSP_RST_BRAKE_SEL        32'h0000_0000
`define DSP_RST_PHASE_RESP       32'h0000_0002
`define DSP_RST_FOLLOW_RESP      32'h0000_0003
`define DSP_RST_MON_EN           32'h0000_0001
`define DSP_RST_EXT_ON_MAX       32'h0000_0001
`define DSP_RST_SOFT_LIM_EN      32'h0000_0000
`define DSP_RST_FOLLOW_LIMIT     32'h0000_2710
`define DSP_RST_SPEED_SRC        32'h0000_0000
`define DSP_RST_SPEED_SETPOINT   32'h0000_0000
`define DSP_EXT_ON_MAX_MS        30000
`define DSP_SPEED_BOUND          30000
`define DSP_FOLLOW_LIMIT_MIN     1
`define DSP_FOLLOW_LIMIT_MAX     2000000

// ***************************************************************
// field codes and field positions
// ***************************************************************
`define DSP_SRC_NONE             2'h0
`define DSP_SRC_ANALOG           2'h1
`define DSP_SRC_SETPOINT         2'h2
`define DSP_SOFT_LIM_POS_BIT     0
`define DSP_SOFT_LIM_NEG_BIT     1

// ***************************************************************
// timing
// ***************************************************************
`define DSP_CLK_HZ               20000000
`define DSP_MS_TICK_MS           1
`define DSP_MS_TICK_CYCLES       (`DSP_CLK_HZ / 1000 * `DSP_MS_TICK_MS)

`endif

// ===== design/dsp_sync.v
// three-flop input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module dsp_sync (
  input  wire i_clk,
  input  wire i_nrst,
  input  wire i_async,
  output reg  o_level
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/dsp_param_reg.v
// one range-checked parameter register
`timescale 1ns/10ps
`default_nettype none
module dsp_param_reg #(
  parameter         W     = 16,
  parameter         SGN   = 0,
  parameter [31:0]  RESET = 32'h0000_0000,
  parameter integer MIN   = 0,
  parameter integer MAX   = 1
) (
  input  wire         i_clk,
  input  wire         i_nrst,
  input  wire         i_we,
  input  wire [31:0]  i_wdata,
  output reg  [W-1:0] o_value,
  output wire         o_reject
);
  localparam signed [32:0] LO = MIN;
  localparam signed [32:0] HI = MAX;

  wire [32:0] ext = (SGN != 0) ? {{(33-W){i_wdata[W-1]}}, i_wdata[W-1:0]}
                               : {{(33-W){1'b0}}, i_wdata[W-1:0]};
  wire        in_range = ($signed(ext) >= LO) && ($signed(ext) <= HI);

  // out-of-range data never reaches the stored value
  assign o_reject = i_we & ~in_range;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_value <= RESET[W-1:0];
    end else if (i_we && in_range) begin
      o_value <= i_wdata[W-1:0];
    end
  end
endmodule
`default_nettype wire

// ===== design/dsp_params.v
// drive supervision parameter bank with brake, speed, fault and soft-limit logic
//
// Overview of operation
// - External brake resistor switch-in time is capped, 1 to 30000 ms.
// - Selection 0 uses the internal resistor, 1 the external one.
// - Setpoint is signed -30000..30000, default 0, clamped to maximum speed.
// - Speed source: 0 none, 1 analog input, 2 setpoint parameter.
// - Three-phase unit reports lost mains phase with class 1, 2 or 3.
// - Following error reported with class 1 to 3, default 3.
// - Ground-fault monitoring on when enable is 1 (default), off at 0.
// - Mains phase monitoring on when enable is 1 (default), off at 0.
// - Following error is offset minus speed part, compared to revolution limit.
// - Soft limits: 0 none, 1 positive, 2 negative, 3 both.
// - Soft limits are checked only after homing has completed.
`timescale 1ns/10ps
`default_nettype none
`include "dsp_consts.vh"
module dsp_params #(
  parameter        MS_CYCLES     = `DSP_MS_TICK_CYCLES,
  parameter [15:0] INT_BRAKE_RES = 16'h0000,
  parameter [15:0] INT_BRAKE_PWR = 16'h0000
) (
  input  wire        I_CORE_CLK,
  input  wire        I_NRST,
  input  wire        I_PAR_WR,
  input  wire        I_PAR_RD,
  input  wire [15:0] I_PAR_ADDR,
  input  wire [31:0] I_PAR_WDATA,
  output reg  [31:0] O_PAR_RDATA,
  output reg         O_PAR_ACK,
  output reg         O_PAR_ERR,
  input  wire        I_BRAKE_DEMAND,
  output wire        O_BRAKE_INT_ON,
  output wire        O_BRAKE_EXT_ON,
  output wire        O_BRAKE_EXT_TIMEOUT,
  input  wire [15:0] I_ANALOG_SPEED,
  input  wire [15:0] I_SPEED_MAX,
  output reg  [15:0] O_SPEED_REF,
  input  wire        I_THREE_PHASE,
  input  wire        I_PHASE_LOST,
  output reg         O_PHASE_FAULT,
  output reg  [1:0]  O_PHASE_FAULT_CLASS,
  input  wire        I_GROUND_FAULT,
  output reg         O_GROUND_FAULT,
  input  wire [31:0] I_POS_OFFSET,
  input  wire [31:0] I_POS_OFFSET_SPEED,
  output reg         O_FOLLOW_FAULT,
  output reg  [1:0]  O_FOLLOW_FAULT_CLASS,
  input  wire        I_HOMING_DONE,
  input  wire        I_AT_POS_LIMIT,
  input  wire        I_AT_NEG_LIMIT,
  output reg         O_SOFT_LIMIT_POS_HIT,
  output reg         O_SOFT_LIMIT_NEG_HIT
);

  // ***************************************************************
  // parameter storage
  // ***************************************************************
  wire        wr_en = I_PAR_WR;
  wire [15:0] brake_resistor_select;
  wire [15:0] phase_loss_response;
  wire [15:0] following_error_response;
  wire [15:0] phase_monitor_enable;
  wire [15:0] ground_fault_monitor_enable;
  wire [15:0] ext_brake_on_time_max;
  wire [15:0] soft_limit_enable;
  wire [31:0] following_error_limit;
  wire [15:0] speed_source_select;
  wire [15:0] speed_setpoint;
  wire [9:0]  rej;

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_BRAKE_SEL), .MIN(0), .MAX(1)) u_brake_sel (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_BRAKE_SEL),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (brake_resistor_select),
    .o_reject (rej[0])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_PHASE_RESP), .MIN(1), .MAX(3)) u_phase_resp (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_PHASE_RESP),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (phase_loss_response),
    .o_reject (rej[1])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_FOLLOW_RESP), .MIN(1), .MAX(3)) u_follow_resp (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_FOLLOW_RESP),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (following_error_response),
    .o_reject (rej[2])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_MON_EN), .MIN(0), .MAX(1)) u_phase_en (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_PHASE_MON_EN),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (phase_monitor_enable),
    .o_reject (rej[3])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_MON_EN), .MIN(0), .MAX(1)) u_ground_en (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_GROUND_MON_EN),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (ground_fault_monitor_enable),
    .o_reject (rej[4])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_EXT_ON_MAX), .MIN(1),
                  .MAX(`DSP_EXT_ON_MAX_MS)) u_ext_on_max (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_EXT_ON_MAX),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (ext_brake_on_time_max),
    .o_reject (rej[5])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_SOFT_LIM_EN), .MIN(0), .MAX(3)) u_soft_en (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_SOFT_LIM_EN),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (soft_limit_enable),
    .o_reject (rej[6])
  );

  dsp_param_reg #(.W(32), .SGN(0), .RESET(`DSP_RST_FOLLOW_LIMIT), .MIN(`DSP_FOLLOW_LIMIT_MIN),
                  .MAX(`DSP_FOLLOW_LIMIT_MAX)) u_follow_lim (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_FOLLOW_LIMIT),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (following_error_limit),
    .o_reject (rej[7])
  );

  dsp_param_reg #(.W(16), .SGN(0), .RESET(`DSP_RST_SPEED_SRC), .MIN(0), .MAX(2)) u_speed_src (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_SPEED_SRC),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (speed_source_select),
    .o_reject (rej[8])
  );

  dsp_param_reg #(.W(16), .SGN(1), .RESET(`DSP_RST_SPEED_SETPOINT), .MIN(-`DSP_SPEED_BOUND),
                  .MAX(`DSP_SPEED_BOUND)) u_speed_set (
    .i_clk    (I_CORE_CLK),
    .i_nrst   (I_NRST),
    .i_we     (wr_en && I_PAR_ADDR == `DSP_ADDR_SPEED_SETPOINT),
    .i_wdata  (I_PAR_WDATA),
    .o_value  (speed_setpoint),
    .o_reject (rej[9])
  );

  // ***************************************************************
  // parameter access answer
  // ***************************************************************
  reg        addr_rw;
  reg        addr_ro;
  reg [31:0] rd_mux;

  always @* begin
    addr_rw = 1'b1;
    addr_ro = 1'b0;
    rd_mux  = 32'h0000_0000;
    case (I_PAR_ADDR)
      `DSP_ADDR_BRAKE_SEL:      rd_mux = {16'h0000, brake_resistor_select};
      `DSP_ADDR_PHASE_RESP:     rd_mux = {16'h0000, phase_loss_response};
      `DSP_ADDR_FOLLOW_RESP:    rd_mux = {16'h0000, following_error_response};
      `DSP_ADDR_PHASE_MON_EN:   rd_mux = {16'h0000, phase_monitor_enable};
      `DSP_ADDR_GROUND_MON_EN:  rd_mux = {16'h0000, ground_fault_monitor_enable};
      `DSP_ADDR_EXT_ON_MAX:     rd_mux = {16'h0000, ext_brake_on_time_max};
      `DSP_ADDR_SOFT_LIM_EN:    rd_mux = {16'h0000, soft_limit_enable};
      `DSP_ADDR_FOLLOW_LIMIT:   rd_mux = following_error_limit;
      `DSP_ADDR_SPEED_SRC:      rd_mux = {16'h0000, speed_source_select};
      `DSP_ADDR_SPEED_SETPOINT: rd_mux = {16'h0000, speed_setpoint};
      `DSP_ADDR_INT_BRAKE_RES: begin
        rd_mux  = {16'h0000, INT_BRAKE_RES};
        addr_rw = 1'b0;
        addr_ro = 1'b1;
      end
      `DSP_ADDR_INT_BRAKE_PWR: begin
        rd_mux  = {16'h0000, INT_BRAKE_PWR};
        addr_rw = 1'b0;
        addr_ro = 1'b1;
      end
      default: addr_rw = 1'b0;
    endcase
  end

  // a write wins over a read issued in the same cycle
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PAR_ACK   <= 1'b0;
      O_PAR_ERR   <= 1'b0;
      O_PAR_RDATA <= 32'h0000_0000;
    end else begin
      O_PAR_ACK <= I_PAR_WR | I_PAR_RD;
      if (I_PAR_WR) begin
        O_PAR_ERR <= ~addr_rw | (|rej);
      end else if (I_PAR_RD) begin
        O_PAR_ERR   <= ~(addr_rw | addr_ro);
        O_PAR_RDATA <= rd_mux;
      end else begin
        O_PAR_ERR <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // brake resistor control
  // ***************************************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_INT  = 4'h2;
  localparam [3:0] ST_EXT  = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;
  localparam [14:0] MS_LAST = MS_CYCLES[14:0] - 15'h0001;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [14:0] ms_pre;
  reg  [15:0] ms_cnt;
  wire        ext_sel = brake_resistor_select[0];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (I_BRAKE_DEMAND) begin
          next_state = ext_sel ? ST_EXT : ST_INT;
        end
      end
      ST_INT: begin
        if (!I_BRAKE_DEMAND) begin
          next_state = ST_IDLE;
        end else if (ext_sel) begin
          next_state = ST_EXT;
        end
      end
      ST_EXT: begin
        if (!I_BRAKE_DEMAND) begin
          next_state = ST_IDLE;
        end else if (!ext_sel) begin
          next_state = ST_INT;
        end else if (ms_cnt >= ext_brake_on_time_max) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // released only by dropping the demand, so the resistor cools down
        if (!I_BRAKE_DEMAND) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state  <= ST_IDLE;
      ms_pre <= 15'h0000;
      ms_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      if (state != ST_EXT) begin
        ms_pre <= 15'h0000;
        ms_cnt <= 16'h0000;
      end else if (ms_pre == MS_LAST) begin
        ms_pre <= 15'h0000;
        ms_cnt <= ms_cnt + 16'h0001;
      end else begin
        ms_pre <= ms_pre + 15'h0001;
      end
    end
  end

  assign O_BRAKE_INT_ON      = state[1];
  assign O_BRAKE_EXT_ON      = state[2];
  assign O_BRAKE_EXT_TIMEOUT = state[3];

  // ***************************************************************
  // speed reference
  // ***************************************************************
  reg  signed [16:0] spd_sel;
  wire signed [16:0] spd_max = {1'b0, I_SPEED_MAX};

  always @* begin
    case (speed_source_select[1:0])
      `DSP_SRC_ANALOG:   spd_sel = {I_ANALOG_SPEED[15], I_ANALOG_SPEED};
      `DSP_SRC_SETPOINT: spd_sel = {speed_setpoint[15], speed_setpoint};
      default:           spd_sel = 17'h00000;
    endcase
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SPEED_REF <= 16'h0000;
    end else if (spd_sel > spd_max) begin
      O_SPEED_REF <= spd_max[15:0];
    end else if (spd_sel < -spd_max) begin
      O_SPEED_REF <= -spd_max[15:0];
    end else begin
      O_SPEED_REF <= spd_sel[15:0];
    end
  end

  // ***************************************************************
  // mains, ground and following-error supervision
  // ***************************************************************
  wire three_phase_s;
  wire phase_lost_s;
  wire ground_fault_s;

  dsp_sync u_sync_3ph (
    .i_clk   (I_CORE_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_THREE_PHASE),
    .o_level (three_phase_s)
  );

  dsp_sync u_sync_phase (
    .i_clk   (I_CORE_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_PHASE_LOST),
    .o_level (phase_lost_s)
  );

  dsp_sync u_sync_ground (
    .i_clk   (I_CORE_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_GROUND_FAULT),
    .o_level (ground_fault_s)
  );

  // 33 bits so the difference of two full-range offsets cannot wrap
  wire signed [32:0] follow_err = $signed({I_POS_OFFSET[31], I_POS_OFFSET})
                                - $signed({I_POS_OFFSET_SPEED[31], I_POS_OFFSET_SPEED});
  wire        [32:0] follow_abs = follow_err[32] ? (~follow_err + 33'h000000001) : follow_err;

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PHASE_FAULT        <= 1'b0;
      O_PHASE_FAULT_CLASS  <= 2'h0;
      O_GROUND_FAULT       <= 1'b0;
      O_FOLLOW_FAULT       <= 1'b0;
      O_FOLLOW_FAULT_CLASS <= 2'h0;
      O_SOFT_LIMIT_POS_HIT <= 1'b0;
      O_SOFT_LIMIT_NEG_HIT <= 1'b0;
    end else begin
      O_PHASE_FAULT        <= three_phase_s & phase_monitor_enable[0] & phase_lost_s;
      O_PHASE_FAULT_CLASS  <= phase_loss_response[1:0];
      O_GROUND_FAULT       <= ground_fault_monitor_enable[0] & ground_fault_s;
      O_FOLLOW_FAULT       <= follow_abs > {1'b0, following_error_limit};
      O_FOLLOW_FAULT_CLASS <= following_error_response[1:0];
      O_SOFT_LIMIT_POS_HIT <= I_HOMING_DONE & I_AT_POS_LIMIT
                              & soft_limit_enable[`DSP_SOFT_LIM_POS_BIT];
      O_SOFT_LIMIT_NEG_HIT <= I_HOMING_DONE & I_AT_NEG_LIMIT
                              & soft_limit_enable[`DSP_SOFT_LIM_NEG_BIT];
    end
  end

endmodule
`default_nettype wire

// ===== tb/dsp_params_monitor.sv
// concurrent checks on the parameter bank ports
`timescale 1ns/10ps
`default_nettype none
module dsp_params_monitor #(
  parameter MS_CYCLES = 4
) (
  input wire logic        I_CORE_CLK,
  input wire logic        I_NRST,
  input wire logic        I_PAR_WR,
  input wire logic        I_PAR_RD,
  input wire logic        O_PAR_ACK,
  input wire logic        O_PAR_ERR,
  input wire logic        I_BRAKE_DEMAND,
  input wire logic        O_BRAKE_INT_ON,
  input wire logic        O_BRAKE_EXT_ON,
  input wire logic        O_BRAKE_EXT_TIMEOUT,
  input wire logic [15:0] I_SPEED_MAX,
  input wire logic [15:0] O_SPEED_REF,
  input wire logic        O_PHASE_FAULT,
  input wire logic [1:0]  O_PHASE_FAULT_CLASS,
  input wire logic        O_FOLLOW_FAULT,
  input wire logic [1:0]  O_FOLLOW_FAULT_CLASS,
  input wire logic        I_HOMING_DONE,
  input wire logic        I_AT_POS_LIMIT,
  input wire logic        I_AT_NEG_LIMIT,
  input wire logic        O_SOFT_LIMIT_POS_HIT,
  input wire logic        O_SOFT_LIMIT_NEG_HIT
);
  logic [31:0] ext_cnt;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  // run length of the external resistor, capped by the largest legal maximum
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST)
      ext_cnt <= 32'h0;
    else
      ext_cnt <= O_BRAKE_EXT_ON ? ext_cnt + 32'h1 : 32'h0;
  end
  sequence s_req;
    I_PAR_WR || I_PAR_RD;
  endsequence
  sequence s_brake_off;
    !O_BRAKE_INT_ON && !O_BRAKE_EXT_ON && !O_BRAKE_EXT_TIMEOUT;
  endsequence
  a_ack_after_request: assert property (s_req |=> O_PAR_ACK)
    else $error("no acknowledge after request");
  a_ack_needs_request: assert property (!(I_PAR_WR || I_PAR_RD) |=> !O_PAR_ACK)
    else $error("acknowledge without request");
  a_err_with_ack: assert property (O_PAR_ERR |-> O_PAR_ACK)
    else $error("error flag outside acknowledge");
  a_brake_answers: assert property (I_BRAKE_DEMAND && !O_BRAKE_EXT_TIMEOUT |=>
    O_BRAKE_INT_ON || O_BRAKE_EXT_ON || O_BRAKE_EXT_TIMEOUT)
    else $error("brake demand ignored");
  a_brake_release: assert property (!I_BRAKE_DEMAND |=> s_brake_off)
    else $error("brake held without demand");
  a_brake_one_hot: assert property ($onehot0({O_BRAKE_INT_ON, O_BRAKE_EXT_ON,
    O_BRAKE_EXT_TIMEOUT})) else $error("two brake states at once");
  a_ext_on_capped: assert property (ext_cnt <= 30000 * MS_CYCLES + 2)
    else $error("external resistor on too long");
  a_speed_in_bounds: assert property (
    $signed(O_SPEED_REF) <= $signed({1'b0, $past(I_SPEED_MAX)})
    && $signed(O_SPEED_REF) >= -$signed({1'b0, $past(I_SPEED_MAX)}))
    else $error("speed reference beyond limit");
  a_pos_hit_homed: assert property (O_SOFT_LIMIT_POS_HIT |-> $past(I_HOMING_DONE)
    && $past(I_AT_POS_LIMIT)) else $error("positive hit without cause");
  a_neg_hit_homed: assert property (O_SOFT_LIMIT_NEG_HIT |-> $past(I_HOMING_DONE)
    && $past(I_AT_NEG_LIMIT)) else $error("negative hit without cause");
  a_follow_class_set: assert property (O_FOLLOW_FAULT |->
    O_FOLLOW_FAULT_CLASS != 2'h0) else $error("following fault without class");
  a_phase_class_set: assert property (O_PHASE_FAULT |-> O_PHASE_FAULT_CLASS != 2'h0)
    else $error("phase fault without class");
endmodule
`default_nettype wire

// ===== tb/dsp_bus_master.sv
// fieldbus master model issuing single-cycle parameter requests
`timescale 1ns/10ps
`default_nettype none
module dsp_bus_master (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic [31:0] i_rdata,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [15:0] o_addr,
  output var  logic [31:0] o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 16'hffff;
    o_wdata = 32'hffff_ffff;
  end
  // request is a one-cycle pulse; a held strobe would be taken twice
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [1:0] e, output logic [31:0] q);
    @(negedge i_clk);
    o_wr    = w;
    o_rd    = !w;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
    e       = {i_ack, i_err};
    q       = i_rdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/dsp_params_bench.sv
// self-checking bench for the drive supervision parameter bank
`timescale 1ns/10ps
`default_nettype none
module dsp_params_bench;
  localparam int MS = 4;
  localparam logic [15:0] RA [12] = '{16'h0512, 16'h0514, 16'h0516, 16'h051e, 16'h0520,
    16'h0522, 16'h0606, 16'h1010, 16'h1012, 16'h121c, 16'h1b22, 16'h2108};
  localparam logic [31:0] RV [12] = '{32'h0, 32'h2, 32'h3, 32'h1, 32'h1, 32'h1, 32'h0,
    32'ha5, 32'h5a, 32'h2710, 32'h0, 32'h0};
  localparam logic [15:0] GA [10] = '{16'h0512, 16'h0514, 16'h0516, 16'h051e, 16'h0520,
    16'h0522, 16'h0606, 16'h121c, 16'h1b22, 16'h2108};
  localparam logic [31:0] GD [10] = '{32'h1, 32'h3, 32'h1, 32'h0, 32'h1, 32'h7530, 32'h3,
    32'h1e_8480, 32'h2, 32'h8ad0};
  localparam logic [31:0] BD [10] = '{32'h2, 32'h0, 32'h4, 32'h2, 32'h2, 32'h7531, 32'h4,
    32'h1e_8481, 32'h3, 32'h7531};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr, rd, ack, err;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic        demand = 1'b0;
  logic        int_on, ext_on, ext_to;
  logic [15:0] analog = 16'h0;
  logic [15:0] smax = 16'h0;
  logic [15:0] sref;
  logic        three = 1'b0;
  logic        lost = 1'b0;
  logic        ground = 1'b0;
  logic        pfault, gfault, ffault, pos_hit, neg_hit;
  logic [1:0]  pclass, fclass;
  logic [31:0] offs = 32'h0;
  logic [31:0] offs_spd = 32'h0;
  logic        homed = 1'b0, at_pos = 1'b0, at_neg = 1'b0;
  int          fails = 0;
  int          checked = 0;
  always #25 clk = ~clk;
  dsp_bus_master dsp_bus_master_i (.i_clk(clk), .i_ack(ack), .i_err(err), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  dsp_params #(.MS_CYCLES(MS), .INT_BRAKE_RES(16'h00a5), .INT_BRAKE_PWR(16'h005a)) dsp_params_i (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_PAR_WR(wr), .I_PAR_RD(rd), .I_PAR_ADDR(addr),
    .I_PAR_WDATA(wdata), .O_PAR_RDATA(rdata), .O_PAR_ACK(ack), .O_PAR_ERR(err),
    .I_BRAKE_DEMAND(demand), .O_BRAKE_INT_ON(int_on), .O_BRAKE_EXT_ON(ext_on),
    .O_BRAKE_EXT_TIMEOUT(ext_to), .I_ANALOG_SPEED(analog), .I_SPEED_MAX(smax),
    .O_SPEED_REF(sref), .I_THREE_PHASE(three), .I_PHASE_LOST(lost), .O_PHASE_FAULT(pfault),
    .O_PHASE_FAULT_CLASS(pclass), .I_GROUND_FAULT(ground), .O_GROUND_FAULT(gfault),
    .I_POS_OFFSET(offs), .I_POS_OFFSET_SPEED(offs_spd), .O_FOLLOW_FAULT(ffault),
    .O_FOLLOW_FAULT_CLASS(fclass), .I_HOMING_DONE(homed), .I_AT_POS_LIMIT(at_pos),
    .I_AT_NEG_LIMIT(at_neg), .O_SOFT_LIMIT_POS_HIT(pos_hit), .O_SOFT_LIMIT_NEG_HIT(neg_hit));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask
  task automatic wrp(input logic [15:0] a, input logic [31:0] d, input logic ee);
    logic [1:0] e;
    logic [31:0] q;
    dsp_bus_master_i.xfer(1'b1, a, d, e, q);
    chk("write answer", {30'h0, 1'b1, ee}, {30'h0, e});
  endtask
  task automatic rdp(input logic [15:0] a, input logic [31:0] x, input logic ee);
    logic [1:0] e;
    logic [31:0] q;
    dsp_bus_master_i.xfer(1'b0, a, 32'h0, e, q);
    chk("read answer", {30'h0, 1'b1, ee}, {30'h0, e});
    chk("read data", x, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset_vals;
    for (int k = 0; k < 12; k++)
      rdp(RA[k], RV[k], 1'b0);
  endtask
  task automatic t_ranges;
    for (int k = 0; k < 10; k++) begin
      wrp(GA[k], GD[k], 1'b0);
      wrp(GA[k], BD[k], 1'b1);
      rdp(GA[k], GD[k], 1'b0);
    end
    wrp(16'h1010, 32'h1, 1'b1);
    rdp(16'h1010, 32'ha5, 1'b0);
    rdp(16'h0004, 32'h0, 1'b1);
  endtask
  task automatic t_brake;
    int n;
    n = 0;
    wrp(16'h0512, 32'h0, 1'b0);
    demand = 1'b1;
    settle(1);
    chk("internal resistor", 32'h1, {31'h0, int_on});
    demand = 1'b0;
    wrp(16'h0522, 32'h2, 1'b0);
    wrp(16'h0512, 32'h1, 1'b0);
    demand = 1'b1;
    settle(1);
    while (ext_on === 1'b1 && n < 100) begin
      n++;
      settle(1);
    end
    chk("external on span", 32'h1, {31'h0, n >= 2 * MS && n <= 2 * MS + 2});
    chk("external timeout", 32'h1, {31'h0, ext_to});
    demand = 1'b0;
    settle(1);
    chk("brake idle", 32'h0, {29'h0, int_on, ext_on, ext_to});
  endtask
  task automatic t_speed;
    smax = 16'd1000;
    analog = 16'd500;
    wrp(16'h1b22, 32'h0, 1'b0);
    settle(2);
    chk("speed none", 32'h0, {16'h0, sref});
    wrp(16'h1b22, 32'h1, 1'b0);
    settle(2);
    chk("speed analog", 32'h1f4, {16'h0, sref});
    analog = 16'hf830;
    settle(2);
    chk("speed clamp", 32'hfc18, {16'h0, sref});
    wrp(16'h2108, 32'h7530, 1'b0);
    wrp(16'h1b22, 32'h2, 1'b0);
    settle(2);
    chk("speed setpoint", 32'h3e8, {16'h0, sref});
    wrp(16'h2108, 32'hfed4, 1'b0);
    settle(2);
    chk("speed negative", 32'hfed4, {16'h0, sref});
  endtask
  task automatic t_faults;
    wrp(16'h0520, 32'h1, 1'b0);
    ground = 1'b1;
    settle(6);
    chk("ground fault", 32'h1, {31'h0, gfault});
    wrp(16'h0520, 32'h0, 1'b0);
    settle(2);
    chk("ground masked", 32'h0, {31'h0, gfault});
    wrp(16'h0514, 32'h1, 1'b0);
    wrp(16'h051e, 32'h1, 1'b0);
    three = 1'b1;
    lost = 1'b1;
    settle(6);
    chk("phase fault", 32'h5, {29'h0, pfault, pclass});
    wrp(16'h051e, 32'h0, 1'b0);
    settle(2);
    chk("phase masked", 32'h0, {31'h0, pfault});
    wrp(16'h051e, 32'h1, 1'b0);
    three = 1'b0;
    settle(6);
    chk("single phase unit", 32'h0, {31'h0, pfault});
  endtask
  task automatic t_follow;
    wrp(16'h121c, 32'h2710, 1'b0);
    wrp(16'h0516, 32'h3, 1'b0);
    offs = 32'h3a98;
    offs_spd = 32'h1387;
    settle(2);
    chk("follow fault", 32'h7, {29'h0, ffault, fclass});
    wrp(16'h0516, 32'h2, 1'b0);
    settle(2);
    chk("follow class", 32'h6, {29'h0, ffault, fclass});
    offs_spd = 32'h1388;
    settle(2);
    chk("follow at limit", 32'h0, {31'h0, ffault});
  endtask
  task automatic t_soft;
    at_pos = 1'b1;
    at_neg = 1'b1;
    wrp(16'h0606, 32'h3, 1'b0);
    settle(2);
    chk("limits before homing", 32'h0, {30'h0, pos_hit, neg_hit});
    homed = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wrp(16'h0606, k, 1'b0);
      settle(2);
      chk("limit hits", {30'h0, k[0], k[1]}, {30'h0, pos_hit, neg_hit});
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #250000;
    fails++;
    final_report;
  end
  initial begin
    settle(6);
    nrst = 1'b1;
    t_reset_vals;
    t_ranges;
    t_brake;
    t_speed;
    t_faults;
    t_follow;
    t_soft;
    final_report;
  end
endmodule
bind dsp_params dsp_params_monitor #(.MS_CYCLES(MS_CYCLES)) dsp_params_monitor_i (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_PAR_WR(I_PAR_WR), .I_PAR_RD(I_PAR_RD),
  .O_PAR_ACK(O_PAR_ACK), .O_PAR_ERR(O_PAR_ERR), .I_BRAKE_DEMAND(I_BRAKE_DEMAND),
  .O_BRAKE_INT_ON(O_BRAKE_INT_ON), .O_BRAKE_EXT_ON(O_BRAKE_EXT_ON),
  .O_BRAKE_EXT_TIMEOUT(O_BRAKE_EXT_TIMEOUT), .I_SPEED_MAX(I_SPEED_MAX),
  .O_SPEED_REF(O_SPEED_REF), .O_PHASE_FAULT(O_PHASE_FAULT),
  .O_PHASE_FAULT_CLASS(O_PHASE_FAULT_CLASS), .O_FOLLOW_FAULT(O_FOLLOW_FAULT),
  .O_FOLLOW_FAULT_CLASS(O_FOLLOW_FAULT_CLASS), .I_HOMING_DONE(I_HOMING_DONE),
  .I_AT_POS_LIMIT(I_AT_POS_LIMIT), .I_AT_NEG_LIMIT(I_AT_NEG_LIMIT),
  .O_SOFT_LIMIT_POS_HIT(O_SOFT_LIMIT_POS_HIT), .O_SOFT_LIMIT_NEG_HIT(O_SOFT_LIMIT_NEG_HIT));
`default_nettype wire
